// File: pkg/lpr_pkg.sv
package lpr_pkg;
    // ------------------------------------------------------------
    // register map (word offsets are byte addresses)
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_LPC = 4'h0;
    localparam logic [3:0] ADDR_RCR = 4'h4;
    localparam logic [3:0] ADDR_RSR = 4'h8;
    localparam logic [3:0] ADDR_PGM = 4'hC;
    localparam logic [7:0] RCR_RESET = 8'h05;
    localparam int RCR_SOFT = 7;
    localparam int RCR_FORCE = 6;
    localparam int RCR_LVDF = 4;
    localparam int RCR_LVDIE = 3;
    localparam int RCR_LVDRE = 2;
    localparam int RCR_LVDE = 0;
    localparam logic [7:0] RCR_WMASK = 8'hCD;
    // reset cause bit positions in status
    localparam int SRC_EXT = 0;
    localparam int SRC_POR = 1;
    localparam int SRC_WDT = 2;
    localparam int SRC_LOL = 3;
    localparam int SRC_LOC = 4;
    localparam int SRC_SOFT = 5;
    localparam int SRC_LVD = 6;
    localparam int NUM_SRC = 7;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int EXT_MIN_EDGES = 4;
    localparam int RST_HOLD_CYC = 16;
    localparam logic [4:0] RST_HOLD_LAST = 5'h0F;
    // ------------------------------------------------------------
    // modes and peripheral enables
    // ------------------------------------------------------------
    typedef enum logic [1:0] {LPR_RUN, LPR_WAIT, LPR_DOZE, LPR_STOP} lpr_mode_t;
    typedef struct packed {
        logic cpu_mem;
        logic sys_group;
        logic always_on;
        logic eport_wake;
        logic pit;
        logic adc;
        logic pwm;
    } lpr_run_t;
    typedef struct packed {
        logic ext;
        logic por;
        logic wdt;
        logic lol;
        logic loc;
    } lpr_src_t;
endpackage

// File: logic/lpr_ctrl.sv
// Decided for this implementation: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ns
// Summary of operation
// (RQ1) stop instruction moves peripherals into the state the mode select field picks
// (RQ2) cpu and memories halt in all modes; system peripherals halt only in stop
// (RQ3) interrupt, clock, reset and debug stay on; edge port keeps stop wakeup
// (RQ4) timers and adc follow own bits in doze, pwm in doze and wait; all stop in stop
// (RQ5) each peripheral's own disable bit gates it regardless of mode
// (RQ6) debug logic uses the separate debug test clock, not the system clock
// (RQ7) halt entered through debug port leaves any low-power mode
// (RQ8) after halt the prior low-power mode returns, halt-time changes kept
// (RQ9) controller finds reset source, drives system reset, records the cause
// (RQ10) low-voltage detection here yields either an interrupt or a reset
// (RQ11) seven sources: external, power-on, watchdog, lock, clock, software, low-voltage
// (RQ12) software may assert reset output on its own at any time
// (RQ13) readable flags show the cause of the latest reset
// (RQ14) control bits enable detection and pick reset or interrupt
// (RQ15) external reset recognised only after four clock edges held low
// (RQ16) reset output goes low whenever the controller resets the chip
// (RQ17) outside logic drives config data only while reset output is low; the far model drives cfg_o while high too, inverting it each clock
// (RQ18) reset input synchronised except in stop, where it acts at once
// (RQ19) low-voltage reset wins over the low-voltage interrupt
// (RQ20) mode field encoding is a parameter mapping values to the four modes
module lpr_ctrl #(
    parameter logic [7:0] MODE_MAP = 8'hE4,
    parameter int NUM_PERIPH = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic stop_insn_i,
    input wire logic wake_i,
    input wire logic debug_halt_i,
    input wire logic reset_input_n_i,
    input wire lpr_pkg::lpr_src_t src_i,
    input wire logic low_voltage_i,
    input wire logic [NUM_PERIPH-1:0] periph_en_i,
    output lpr_pkg::lpr_run_t run_o,
    output logic [NUM_PERIPH-1:0] periph_run_o,
    output logic [1:0] mode_o,
    output logic sys_reset_o,
    output logic reset_output_n_o,
    output logic lvd_irq_o
);
    import lpr_pkg::*;

    generate
        if (NUM_PERIPH < 1 || NUM_PERIPH > 16)
        begin : g_bad_periph
            $error("NUM_PERIPH out of range");
        end
    endgenerate

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [1:0] lp_sel_q, lp_sel_d;
    logic [7:0] rcr_q, rcr_d;
    logic [NUM_SRC-1:0] rsr_q, rsr_d;
    logic [15:0] pgm_q, pgm_d;
    logic [31:0] dat_q, dat_d;
    logic ack_q, ack_d;
    lpr_mode_t mode_q, mode_d;
    lpr_mode_t saved_q, saved_d;
    logic halted_q, halted_d;
    logic [2:0] ext_cnt_q, ext_cnt_d;
    logic sync1_q, sync2_q;
    logic [4:0] hold_q, hold_d;
    logic in_rst_q, in_rst_d;
    logic [NUM_SRC-1:0] pend_q, pend_d;
    lpr_run_t run_q, run_d;
    logic [NUM_PERIPH-1:0] prun_q, prun_d;
    logic reset_output_n_q, reset_output_n_d;
    logic irq_q, irq_d;
    logic sysr_q, sysr_d;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    logic wr_en, rd_en;
    lpr_mode_t sel_mode;
    logic [NUM_SRC-1:0] req;
    logic lvd_rst, lvd_int, ext_req;
    assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && !ack_q && wb_sel_i[0];
    assign rd_en = wb_cyc_i && wb_stb_i && !ack_q;
    // encoding map
    // (RQ20) parameterised mode map
    assign sel_mode = lpr_mode_t'(MODE_MAP[2*lp_sel_q +: 2]);
    // lvd priority
    // (RQ19) reset over interrupt
    assign lvd_rst = rcr_q[RCR_LVDE] && rcr_q[RCR_LVDRE] && low_voltage_i;
    assign lvd_int = rcr_q[RCR_LVDE] && !rcr_q[RCR_LVDRE] && rcr_q[RCR_LVDIE]
        && rcr_q[RCR_LVDF];
    // stop bypasses the filter: a raw low input resets immediately
    // (RQ18) async path in stop
    assign ext_req = (mode_q == LPR_STOP) ? !reset_input_n_i
        : (ext_cnt_q == 3'(EXT_MIN_EDGES));
    // seven sources
    // (RQ11) gather sources
    always_comb
    begin
        req = '0;
        req[SRC_EXT] = ext_req;
        req[SRC_POR] = src_i.por;
        req[SRC_WDT] = src_i.wdt;
        req[SRC_LOL] = src_i.lol;
        req[SRC_LOC] = src_i.loc;
        req[SRC_SOFT] = rcr_q[RCR_SOFT];
        req[SRC_LVD] = lvd_rst;
    end

    // ------------------------------------------------------------
    // reset input qualification
    // ------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sync1_q <= 1'b1;
            sync2_q <= 1'b1;
        end
        else
        begin
            sync1_q <= reset_input_n_i;
            sync2_q <= sync1_q;
        end
    end

    always_comb
    begin
        // (RQ15) four edge filter
        if (sync2_q)
        begin
            ext_cnt_d = '0;
        end
        else if (ext_cnt_q != 3'(EXT_MIN_EDGES))
        begin
            ext_cnt_d = ext_cnt_q + 3'h1;
        end
        else
        begin
            ext_cnt_d = ext_cnt_q;
        end
    end

    // ------------------------------------------------------------
    // reset sequencing
    // ------------------------------------------------------------
    always_comb
    begin
        pend_d = pend_q | req;
        hold_d = hold_q;
        in_rst_d = in_rst_q;
        rsr_d = rsr_q;
        // (RQ9) detect and hold reset
        if (|req)
        begin
            in_rst_d = 1'b1;
            hold_d = '0;
        end
        else if (in_rst_q && hold_q != RST_HOLD_LAST)
        begin
            hold_d = hold_q + 5'h01;
        end
        else if (in_rst_q)
        begin
            in_rst_d = 1'b0;
            // (RQ13) record cause
            rsr_d = pend_q;
            pend_d = '0;
        end
        // (RQ16) output low in reset
        // (RQ12) software forced output
        reset_output_n_d = !(in_rst_d || rcr_q[RCR_FORCE]);
        sysr_d = in_rst_d;
    end

    // ------------------------------------------------------------
    // mode control
    // ------------------------------------------------------------
    always_comb
    begin
        mode_d = mode_q;
        saved_d = saved_q;
        halted_d = halted_q;
        if (in_rst_q)
        begin
            mode_d = LPR_RUN;
            halted_d = 1'b0;
        end
        // (RQ7) halt exits low power
        else if (debug_halt_i && !halted_q)
        begin
            halted_d = 1'b1;
            saved_d = mode_q;
            mode_d = LPR_RUN;
        end
        // (RQ8) restore prior mode
        else if (!debug_halt_i && halted_q)
        begin
            halted_d = 1'b0;
            mode_d = saved_q;
        end
        else if (!halted_q && wake_i)
        begin
            mode_d = LPR_RUN;
        end
        // (RQ1) stop instruction entry
        else if (!halted_q && stop_insn_i && mode_q == LPR_RUN)
        begin
            mode_d = sel_mode;
        end
    end

    // ------------------------------------------------------------
    // run enables
    // ------------------------------------------------------------
    always_comb
    begin
        // (RQ2) cpu and system group
        run_d.cpu_mem = (mode_q == LPR_RUN);
        run_d.sys_group = (mode_q != LPR_STOP);
        // (RQ3) always-on blocks
        // (RQ6) debug clocked by its own test clock, kept out of gating
        run_d.always_on = 1'b1;
        run_d.eport_wake = 1'b1;
        // (RQ4) programmable halts
        run_d.pit = (mode_q != LPR_STOP) && !(mode_q == LPR_DOZE && pgm_q[0]);
        run_d.adc = (mode_q != LPR_STOP) && !(mode_q == LPR_DOZE && pgm_q[1]);
        run_d.pwm = (mode_q != LPR_STOP) && !(mode_q == LPR_DOZE && pgm_q[2])
            && !(mode_q == LPR_WAIT && pgm_q[3]);
    end

    genvar gi;
    generate
        for (gi = 0; gi < NUM_PERIPH; gi++)
        begin : g_periph
            // (RQ5) local disable
            assign prun_d[gi] = periph_en_i[gi] && (mode_q != LPR_STOP);
        end
    endgenerate

    // ------------------------------------------------------------
    // register bus
    // ------------------------------------------------------------
    always_comb
    begin
        lp_sel_d = lp_sel_q;
        rcr_d = rcr_q;
        pgm_d = pgm_q;
        ack_d = rd_en;
        dat_d = '0;
        // (RQ10) flag on detection
        if (wr_en && wb_adr_i == ADDR_RCR)
        begin
            rcr_d = (rcr_q & ~RCR_WMASK) | (wb_dat_i[7:0] & RCR_WMASK);
            if (wb_dat_i[RCR_LVDF])
            begin
                rcr_d[RCR_LVDF] = 1'b0;
            end
        end
        if (wr_en && wb_adr_i == ADDR_LPC)
        begin
            lp_sel_d = wb_dat_i[1:0];
        end
        if (wr_en && wb_adr_i == ADDR_PGM)
        begin
            pgm_d = {12'h000, wb_dat_i[3:0]};
        end
        // set wins over clear
        if (rcr_q[RCR_LVDE] && low_voltage_i)
        begin
            rcr_d[RCR_LVDF] = 1'b1;
        end
        // software reset bit cleared by the reset it causes
        if (in_rst_q)
        begin
            rcr_d[RCR_SOFT] = 1'b0;
        end
        case (wb_adr_i)
            ADDR_LPC: dat_d = {30'h0000_0000, lp_sel_q};
            ADDR_RCR: dat_d = {24'h00_0000, rcr_q};
            ADDR_RSR: dat_d = {25'h000_0000, rsr_q};
            ADDR_PGM: dat_d = {16'h0000, pgm_q};
            default: dat_d = '0;
        endcase
        // (RQ14) lvd interrupt output
        irq_d = lvd_int;
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            lp_sel_q <= '0;
            rcr_q <= RCR_RESET;
            rsr_q <= '0;
            pgm_q <= '0;
            dat_q <= '0;
            ack_q <= 1'b0;
            mode_q <= LPR_RUN;
            saved_q <= LPR_RUN;
            halted_q <= 1'b0;
            ext_cnt_q <= '0;
            hold_q <= '0;
            in_rst_q <= 1'b0;
            pend_q <= '0;
            run_q <= '0;
            prun_q <= '0;
            reset_output_n_q <= 1'b0;
            irq_q <= 1'b0;
            sysr_q <= 1'b1;
        end
        else
        begin
            lp_sel_q <= lp_sel_d;
            rcr_q <= rcr_d;
            rsr_q <= rsr_d;
            pgm_q <= pgm_d;
            dat_q <= dat_d;
            ack_q <= ack_d;
            mode_q <= mode_d;
            saved_q <= saved_d;
            halted_q <= halted_d;
            ext_cnt_q <= ext_cnt_d;
            hold_q <= hold_d;
            in_rst_q <= in_rst_d;
            pend_q <= pend_d;
            run_q <= run_d;
            prun_q <= prun_d;
            reset_output_n_q <= reset_output_n_d;
            irq_q <= irq_d;
            sysr_q <= sysr_d;
        end
    end

    assign wb_dat_o = dat_q;
    assign wb_ack_o = ack_q;
    assign run_o = run_q;
    assign periph_run_o = prun_q;
    assign mode_o = mode_q;
    assign sys_reset_o = sysr_q;
    assign reset_output_n_o = reset_output_n_q;
    assign lvd_irq_o = irq_q;
endmodule

// File: tb/lpr_ctrl_monitor.sv
`timescale 1ns/1ns
// ----------------
// port checker
// ----------------
module lpr_ctrl_monitor #(
    parameter int NUM_PERIPH = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic debug_halt_i,
    input wire logic reset_input_n_i,
    input wire lpr_pkg::lpr_run_t run_o,
    input wire logic [NUM_PERIPH-1:0] periph_run_o,
    input wire logic [1:0] mode_o,
    input wire logic sys_reset_o,
    input wire logic reset_output_n_o
);
    import lpr_pkg::*;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held too long");
    ack_next_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered");
    pin_low_a: assert property (sys_reset_o |-> !reset_output_n_o)
        else $error("reset pin high in chip reset");
    halt_run_a: assert property ($rose(debug_halt_i) |=> mode_o == LPR_RUN)
        else $error("halt kept low-power mode");
    stop_gate_a: assert property (mode_o == LPR_STOP [*2] |->
        !run_o.sys_group && run_o.eport_wake && periph_run_o == '0)
        else $error("stop gating wrong");
    cpu_off_a: assert property (mode_o != LPR_RUN [*2] |-> !run_o.cpu_mem)
        else $error("cpu runs in low power");
    keep_on_a: assert property (!sys_reset_o [*2] |-> run_o.always_on)
        else $error("always-on group stopped");
    ext_req_a: assert property (!reset_input_n_i [*8] |-> ##[0:4] sys_reset_o)
        else $error("held pin gave no reset");
    rst_hold_a: assert property ($rose(sys_reset_o) |=> sys_reset_o [*8])
        else $error("chip reset too short");
    cover property ($rose(sys_reset_o));
    cover property (mode_o == LPR_STOP);
    cover property ($rose(debug_halt_i) && mode_o == LPR_DOZE);
endmodule

bind lpr_ctrl lpr_ctrl_monitor #(.NUM_PERIPH(NUM_PERIPH)) u_mon (.clk_i, .rst_i,
    .wb_cyc_i, .wb_stb_i, .wb_ack_o, .debug_halt_i, .reset_input_n_i, .run_o,
    .periph_run_o, .mode_o, .sys_reset_o, .reset_output_n_o);

// File: tb/lpr_far_model.sv
`timescale 1ns/1ns
// ----------------
// reset circuitry
// ----------------
module lpr_far_model (
    input wire logic clk_i,
    input wire logic reset_output_n_i,
    output logic reset_input_n_o,
    output logic [7:0] cfg_o
);
    logic pin_q = 1'b1;
    task automatic pull(input int n);
        pin_q <= 1'b0;
        repeat (n) @(posedge clk_i);
        pin_q <= 1'b1;
    endtask
    assign reset_input_n_o = pin_q;
    always @(posedge clk_i)
        cfg_o <= !reset_output_n_i ? 8'h5A : ~cfg_o;
endmodule

// File: tb/lpr_ctrl_tb_top.sv
`timescale 1ns/1ns
module lpr_ctrl_tb_top;
    import lpr_pkg::*;
    logic clk_i = 0, rst_i = 1, wb_we_i = 0, wb_cyc_i = 0, wb_stb_i = 0, pin_n;
    logic stop_insn_i = 0, wake_i = 0, debug_halt_i = 0, low_voltage_i = 0;
    logic [3:0] wb_adr_i = '0, wb_sel_i = 4'h1, sel_next = 4'h1;
    logic [31:0] wb_dat_i = '0, wb_dat_o, rd;
    logic wb_ack_o, sys_reset_o, reset_output_n_o, lvd_irq_o;
    logic [7:0] periph_en_i = 8'hA5, periph_run_o;
    logic [1:0] mode_o;
    lpr_src_t src_i = '0;
    lpr_run_t run_o;
    int n_fail = 0, tests_run = 0;
    lpr_ctrl u_dut (.clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_we_i, .wb_sel_i,
        .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .stop_insn_i, .wake_i,
        .debug_halt_i, .reset_input_n_i(pin_n), .src_i, .low_voltage_i,
        .periph_en_i, .run_o, .periph_run_o, .mode_o, .sys_reset_o,
        .reset_output_n_o, .lvd_irq_o);
    lpr_far_model u_far (.clk_i, .reset_output_n_i(reset_output_n_o),
        .reset_input_n_o(pin_n), .cfg_o());
    initial
        forever #20 clk_i = ~clk_i;
    task automatic tick(input int k);
        repeat (k) @(posedge clk_i);
    endtask
    task automatic chk(input string nm, input logic [31:0] got, exp);
        tests_run++;
        if (got !== exp)
        begin
            n_fail++;
            $display("BAD %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic wrap_up;
        if (n_fail == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // one classic cycle, waits for ack
    task automatic wb(input logic we, input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        wb_cyc_i <= 1;
        wb_stb_i <= 1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_sel_i <= sel_next;
        wb_dat_i <= {24'h00_0000, d};
        do
            @(posedge clk_i);
        while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 0;
        wb_stb_i <= 0;
    endtask
    task automatic pulse(input bit w);
        if (w)
            wake_i <= 1;
        else
            stop_insn_i <= 1;
        tick(1);
        wake_i <= 0;
        stop_insn_i <= 0;
    endtask
    task automatic rst_done(input logic [31:0] cause);
        while (sys_reset_o !== 1'b0)
            @(posedge clk_i);
        tick(3);
        wb(0, ADDR_RSR, 0);
        chk("cause", rd, cause);
    endtask
    task automatic t_reg;
        wb(0, ADDR_RCR, 0);
        chk("ctrl reset", rd, 32'h0000_0005);
        wb(0, 4'h2, 0);
        chk("unmapped", rd, 0);
        sel_next = 4'h0;
        wb(1, ADDR_LPC, 8'h03);
        sel_next = 4'h1;
        wb(0, ADDR_LPC, 0);
        chk("lane off", rd, 0);
    endtask
    task automatic t_mode;
        logic [6:0] exp_run [4] = '{7'h7F, 7'h3E, 7'h38, 7'h18};
        wb(1, ADDR_PGM, 8'h0F);
        for (int m = 1; m < 4; m++)
        begin
            wb(1, ADDR_LPC, 8'(m));
            pulse(0);
            tick(3);
            chk("mode", mode_o, m);
            chk("run set", run_o, exp_run[m]);
            chk("periph", periph_run_o, m == 3 ? 0 : 8'hA5);
            pulse(1);
            tick(3);
            chk("woken", run_o, exp_run[0]);
        end
    endtask
    task automatic t_halt;
        wb(1, ADDR_LPC, 8'h02);
        pulse(0);
        debug_halt_i <= 1;
        tick(3);
        chk("halt", mode_o, 0);
        wb(1, ADDR_PGM, 8'h00);
        debug_halt_i <= 0;
        tick(3);
        chk("back", mode_o, 2);
        chk("kept", run_o, 7'h3F);
        pulse(1);
    endtask
    task automatic t_rcr;
        wb(1, ADDR_RCR, 8'h45);
        tick(2);
        chk("forced", {reset_output_n_o, sys_reset_o}, 0);
        wb(1, ADDR_RCR, 8'h09);
        low_voltage_i <= 1;
        tick(3);
        chk("irq", {lvd_irq_o, sys_reset_o, reset_output_n_o}, 5);
        wb(1, ADDR_RCR, 8'h19);
        wb(0, ADDR_RCR, 0);
        chk("flag kept", rd, 32'h0000_0019);
        low_voltage_i <= 0;
        wb(1, ADDR_RCR, 8'h19);
        tick(2);
        chk("irq clr", lvd_irq_o, 0);
        wb(1, ADDR_RCR, 8'h0D);
        low_voltage_i <= 1;
        tick(3);
        chk("rst wins", {lvd_irq_o, sys_reset_o}, 1);
        low_voltage_i <= 0;
        rst_done(32'h0000_0040);
    endtask
    task automatic t_src;
        u_far.pull(3);
        tick(9);
        chk("short pin", sys_reset_o, 0);
        u_far.pull(10);
        chk("long pin", {sys_reset_o, reset_output_n_o}, 2);
        rst_done(1);
        wb(1, ADDR_LPC, 8'h03);
        pulse(0);
        tick(2);
        u_far.pull(1);
        tick(1);
        chk("stop pin", sys_reset_o, 1);
        rst_done(1);
        pulse(1);
        for (int k = 0; k < 4; k++)
        begin
            src_i <= 5'(8 >> k);
            tick(1);
            src_i <= '0;
            tick(2);
            chk("src hit", sys_reset_o, 1);
            rst_done(2 << k);
        end
        wb(1, ADDR_RCR, 8'h85);
        tick(2);
        chk("soft hit", sys_reset_o, 1);
        rst_done(32'h0000_0020);
    endtask
    initial
    begin
        tick(12);
        rst_i <= 0;
        tick(1);
        t_reg;
        t_mode;
        t_halt;
        t_rcr;
        t_src;
        wrap_up;
    end
    initial
    begin
        #400000;
        n_fail++;
        wrap_up;
    end
endmodule
